// ### hw/ati_pkg.sv
// Package for the analyzer trigger interaction block.
// Assumes a single pclk domain at 100 MHz and an APB register slave.
package ati_pkg;
    // Register byte offsets
    localparam logic [11:0] ATI_CTRL_OFS = 12'h000;
    localparam logic [11:0] ATI_STAT_OFS = 12'h004;
    localparam logic [11:0] ATI_CMD_OFS = 12'h008;
    // Control field positions
    localparam int ATI_P1_BIT = 0;
    localparam int ATI_P2_BIT = 1;
    localparam int ATI_FALL_BIT = 2;
    localparam int ATI_TE_LSB = 3;
    localparam int ATI_XT_LSB = 5;
    localparam int ATI_INT_BIT = 7;
    localparam int ATI_DC_BIT = 8;
    localparam int ATI_WIDE_BIT = 9;
    localparam int ATI_CTRL_W = 10;
    // Command bits
    localparam int ATI_CMD_RESTART = 0;
    // Reset values: internal trigger on, all else off
    localparam logic [31:0] ATI_CTRL_RST = 32'h0000_0080;
    // Pulse width
    localparam int ATI_PULSE_NS = 100;
    localparam int ATI_CLK_NS = 10;
    localparam logic [3:0] ATI_PULSE_CYC =
        4'((ATI_PULSE_NS + ATI_CLK_NS - 1) / ATI_CLK_NS);
    // Option encodings
    typedef enum logic [1:0] {
        ATI_TE_OFF = 2'h0, ATI_TE_DRIVE = 2'h1, ATI_TE_RECV = 2'h2
    } ati_te_t;
    typedef enum logic [1:0] {
        ATI_XT_OFF = 2'h0, ATI_XT_DRIVE = 2'h1, ATI_XT_RECV = 2'h2,
        ATI_XT_BOTH = 2'h3
    } ati_xt_t;
endpackage

// ### hw/ati_pulse_if.sv
// Interface between the trigger core and a pulse port generator.
// Assumes both ends run on pclk.
`timescale 1ns/100ps
interface ati_pulse_if;
    logic enable;
    logic fire;
    logic falling;
    logic level;
    modport core (output enable, output fire, output falling, input level);
    modport gen (input enable, input fire, input falling, output level);
endinterface // ati_pulse_if

// ### hw/ati_pulse_gen.sv
// Fixed-width pulse generator for one output port.
// Assumes fire is a one-cycle pulse on pclk.
`timescale 1ns/100ps
module ati_pulse_gen
    import ati_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    ati_pulse_if.gen pif
);
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic lvl_r;
    logic lvl_nxt;

    // Count down while a pulse is active; off port never starts one
    always_comb begin
        cnt_nxt = cnt_r;
        if (!pif.enable) begin
            cnt_nxt = 4'h0;
        end else if (pif.fire) begin
            cnt_nxt = ATI_PULSE_CYC;
        end else if (cnt_r != 4'h0) begin
            cnt_nxt = cnt_r - 4'h1;
        end
        // Idle level follows polarity so a falling pulse idles high
        lvl_nxt = (cnt_nxt != 4'h0) ^ (pif.falling & pif.enable);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 4'h0;
            lvl_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            lvl_r <= lvl_nxt;
        end
    end

    assign pif.level = lvl_r;

    off_quiet_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !pif.enable |=> !lvl_r)
        else $error("disabled port is active");
    pulse_len_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pif.enable && pif.fire) ##1 (pif.enable && !pif.fire)[*8]
        |-> (lvl_r ^ pif.falling))
        else $error("pulse shorter than expected");
endmodule // ati_pulse_gen

// ### hw/ati_trigger.sv
// Trigger interaction top: APB registers, backplane lines, pulse ports.
// Assumes the trace engine gives trace_match and meas_done on pclk.
// Backplane lines are open-drain style: drive low-active as _o/_oe.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module ati_trigger
    import ati_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic trace_match,
    input wire logic meas_done,
    output logic triggered,
    output logic meas_armed,
    output logic port1_out,
    output logic port2_out,
    input wire logic bp_trig_en_i,
    output logic bp_trig_en_o,
    output logic bp_trig_en_oe,
    input wire logic bp_trig_i,
    output logic bp_trig_o,
    output logic bp_trig_oe,
    input wire logic bp_master_en_i,
    output logic bp_delay_clk_o,
    output logic bp_delay_clk_oe
);
    logic [ATI_CTRL_W-1:0] ctrl_r;
    logic [ATI_CTRL_W-1:0] ctrl_nxt;
    logic trig_r;
    logic trig_nxt;
    logic ten_seen_r;
    logic ten_seen_nxt;
    logic done_r;
    logic done_nxt;
    logic prev_done_r;
    logic [2:0] sy_te_r;
    logic [2:0] sy_tr_r;
    logic [2:0] sy_me_r;
    logic te_in_r;
    logic tr_in_r;
    logic me_in_r;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic wr_acc;
    logic rd_acc;
    logic hit;
    logic restart;
    logic any_opt;
    logic master_ok;
    logic int_ok;
    logic ext_ok;
    logic trig_event;
    logic done_event;
    ati_te_t te_mode;
    ati_xt_t xt_mode;

    ati_pulse_if p1_if();
    ati_pulse_if p2_if();

    // APB decode; zero wait states
    // Reads are captured in the setup cycle, so prdata already stands
    // at the access edge where the master takes it
    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & !penable & !pwrite;
    assign hit = (paddr == ATI_CTRL_OFS) || (paddr == ATI_STAT_OFS)
        || (paddr == ATI_CMD_OFS);
    assign pready = 1'b1;
    assign pslverr = psel & penable & !hit;
    assign prdata = prdata_r;
    assign restart = wr_acc && (paddr == ATI_CMD_OFS)
        && pwdata[ATI_CMD_RESTART];

    assign te_mode = ati_te_t'(ctrl_r[ATI_TE_LSB +: 2]);
    assign xt_mode = ati_xt_t'(ctrl_r[ATI_XT_LSB +: 2]);

    // Three-stage sampling; a change counts when stages two and three agree
    // Stage one feeds only stage two, so a metastable value stays contained
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sy_te_r <= 3'h0;
            sy_tr_r <= 3'h0;
            sy_me_r <= 3'h0;
        end else begin
            sy_te_r <= {sy_te_r[1:0], bp_trig_en_i};
            sy_tr_r <= {sy_tr_r[1:0], bp_trig_i};
            sy_me_r <= {sy_me_r[1:0], bp_master_en_i};
        end
    end

    // Filtered levels, updated only when the last two stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            te_in_r <= 1'b0;
            tr_in_r <= 1'b0;
            me_in_r <= 1'b0;
        end else begin
            if (sy_te_r[2] == sy_te_r[1]) te_in_r <= sy_te_r[2];
            if (sy_tr_r[2] == sy_tr_r[1]) tr_in_r <= sy_tr_r[2];
            if (sy_me_r[2] == sy_me_r[1]) me_in_r <= sy_me_r[2];
        end
    end

    // Master enable gates the start only on the wide variant with options
    always_comb begin
        any_opt = ctrl_r[ATI_P1_BIT] | ctrl_r[ATI_P2_BIT]
            | (te_mode != ATI_TE_OFF) | (xt_mode != ATI_XT_OFF)
            | ctrl_r[ATI_DC_BIT];
        master_ok = !(ctrl_r[ATI_WIDE_BIT] & any_opt) | me_in_r;
        // Receive mode holds off the own trigger; off mode never samples
        int_ok = ctrl_r[ATI_INT_BIT] & trace_match
            & ((te_mode != ATI_TE_RECV) | ten_seen_r);
        ext_ok = tr_in_r & ((xt_mode == ATI_XT_RECV)
            | (xt_mode == ATI_XT_BOTH));
        trig_event = master_ok & !trig_r & (int_ok | ext_ok);
        done_event = meas_done & !prev_done_r & trig_r & !done_r;
    end

    // Control, trigger latch and read data next-state
    always_comb begin
        ctrl_nxt = ctrl_r;
        trig_nxt = trig_r;
        ten_seen_nxt = ten_seen_r;
        done_nxt = done_r;
        prdata_nxt = prdata_r;
        if (wr_acc && (paddr == ATI_CTRL_OFS)) begin
            ctrl_nxt = pwdata[ATI_CTRL_W-1:0];
        end
        // Latched until restart; a new trigger in the same cycle wins
        if (restart) begin
            trig_nxt = 1'b0;
            ten_seen_nxt = 1'b0;
            done_nxt = 1'b0;
        end
        if (te_mode == ATI_TE_RECV && te_in_r) begin
            ten_seen_nxt = 1'b1;
        end
        if (trig_event) begin
            trig_nxt = 1'b1;
        end
        if (done_event) begin
            done_nxt = 1'b1;
        end
        if (rd_acc) begin
            case (paddr)
                ATI_CTRL_OFS: prdata_nxt = {{(32-ATI_CTRL_W){1'b0}}, ctrl_r};
                ATI_STAT_OFS: prdata_nxt = {26'h0, me_in_r, tr_in_r,
                    te_in_r, ten_seen_r, done_r, trig_r};
                default: prdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= ATI_CTRL_RST[ATI_CTRL_W-1:0];
            trig_r <= 1'b0;
            ten_seen_r <= 1'b0;
            done_r <= 1'b0;
            prev_done_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            ctrl_r <= ctrl_nxt;
            trig_r <= trig_nxt;
            ten_seen_r <= ten_seen_nxt;
            done_r <= done_nxt;
            prev_done_r <= meas_done;
            prdata_r <= prdata_nxt;
        end
    end

    // Backplane drivers, registered from the trigger latch next-state, so they rise with triggered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bp_trig_en_oe <= 1'b0;
            bp_trig_oe <= 1'b0;
            bp_delay_clk_oe <= 1'b0;
        end else begin
            bp_trig_en_oe <= (te_mode == ATI_TE_DRIVE) & trig_nxt;
            // Drive mode only on own point; both mode on any source
            bp_trig_oe <= ((xt_mode == ATI_XT_DRIVE) & trig_nxt & (int_ok
                | trig_r)) | ((xt_mode == ATI_XT_BOTH) & trig_nxt);
            bp_delay_clk_oe <= ctrl_r[ATI_DC_BIT] & trig_nxt;
        end
    end

    // Lines are active low while enabled
    assign bp_trig_en_o = 1'b0;
    assign bp_trig_o = 1'b0;
    assign bp_delay_clk_o = 1'b0;
    assign triggered = trig_r;
    assign meas_armed = master_ok;

    // Pulse ports
    assign p1_if.enable = ctrl_r[ATI_P1_BIT];
    assign p1_if.fire = trig_event;
    assign p1_if.falling = ctrl_r[ATI_FALL_BIT];
    assign p2_if.enable = ctrl_r[ATI_P2_BIT];
    assign p2_if.fire = done_event;
    assign p2_if.falling = ctrl_r[ATI_FALL_BIT];
    assign port1_out = p1_if.level;
    assign port2_out = p2_if.level;

    // One generator per port; polarity is shared, enables are not
    ati_pulse_gen u_p1 (
        .pclk(pclk),
        .presetn(presetn),
        .pif(p1_if)
    );
    ati_pulse_gen u_p2 (
        .pclk(pclk),
        .presetn(presetn),
        .pif(p2_if)
    );

    // Trigger path checks
    p1_fire_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (trig_event && ctrl_r[ATI_P1_BIT] && !ctrl_r[ATI_FALL_BIT])
        ##1 ctrl_r[ATI_P1_BIT] |-> port1_out)
        else $error("port one did not pulse on trigger");
    p2_fire_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (done_event && ctrl_r[ATI_P2_BIT] && !ctrl_r[ATI_FALL_BIT])
        ##1 ctrl_r[ATI_P2_BIT] |-> port2_out)
        else $error("port two did not pulse on completion");
    te_off_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (te_mode == ATI_TE_OFF) ##1 (te_mode == ATI_TE_OFF)
        |-> !bp_trig_en_oe)
        else $error("trigger enable driven while off");
    te_drive_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (trig_event && te_mode == ATI_TE_DRIVE) |=> bp_trig_en_oe)
        else $error("trigger enable not driven");
    te_recv_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (te_mode == ATI_TE_RECV && !ten_seen_r && !ext_ok) |-> !trig_event)
        else $error("own trigger not held off");
    master_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ctrl_r[ATI_WIDE_BIT] && any_opt && !me_in_r) |-> !trig_event)
        else $error("trigger before master enable");
    xt_off_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (xt_mode == ATI_XT_OFF) ##1 (xt_mode == ATI_XT_OFF)
        |-> !bp_trig_oe)
        else $error("trigger line driven while off");
    xt_drive_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (trig_event && int_ok && xt_mode == ATI_XT_DRIVE) |=> bp_trig_oe)
        else $error("trigger line not driven on own trigger");
    ext_recv_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (tr_in_r && master_ok && !trig_r && xt_mode == ATI_XT_RECV)
        |-> trig_event)
        else $error("received trigger ignored");
    xt_both_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (trig_event && xt_mode == ATI_XT_BOTH) |=> bp_trig_oe)
        else $error("trigger line not driven after trigger");
    int_on_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ctrl_r[ATI_INT_BIT] && trace_match && master_ok && !trig_r
        && (te_mode != ATI_TE_RECV || ten_seen_r)) |-> trig_event)
        else $error("trace match did not trigger");
    int_off_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!ctrl_r[ATI_INT_BIT] && !ext_ok) |-> !trig_event)
        else $error("internal trigger while disabled");
    latch_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (trig_r && !restart) |=> trig_r)
        else $error("trigger latch lost");
    dclk_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (trig_r && ctrl_r[ATI_DC_BIT]) ##1 ctrl_r[ATI_DC_BIT] ##0 trig_r
        |-> bp_delay_clk_oe)
        else $error("delay clock not driven");
    // Read data must show the control word captured at setup
    rd_ctrl_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == ATI_CTRL_OFS)
        |=> (prdata == {{(32-ATI_CTRL_W){1'b0}}, $past(ctrl_r)}))
        else $error("read data not ready at access");

    // Main scenarios
    fall_pulse_c: cover property (@(posedge pclk) disable iff (!presetn)
        trig_event && ctrl_r[ATI_P1_BIT] && ctrl_r[ATI_FALL_BIT]);
    trig_int_c: cover property (@(posedge pclk) disable iff (!presetn)
        trig_event && int_ok);
    trig_ext_c: cover property (@(posedge pclk) disable iff (!presetn)
        trig_event && ext_ok && !int_ok);
    done_c: cover property (@(posedge pclk) disable iff (!presetn)
        done_event && ctrl_r[ATI_P2_BIT]);
    restart_c: cover property (@(posedge pclk) disable iff (!presetn)
        trig_r ##1 restart);
endmodule // ati_trigger

// ### sim/ati_far_model.sv
// Far-end model: other analysis modules sharing the backplane lines.
// Assumes open-drain lines that pull-ups return to the deasserted level.
`timescale 1ns/100ps
module ati_far_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] lag,
    input wire logic req_te,
    input wire logic req_trig,
    input wire logic req_master,
    input wire logic te_oe,
    input wire logic trig_oe,
    output logic bp_trig_en_i,
    output logic bp_trig_i,
    output logic bp_master_en_i
);
    logic [2:0] te_r, trig_r, mst_r;
    logic [2:0] te_nxt, trig_nxt, mst_nxt;
    logic te_drv, trig_drv, mst_drv;
    // Delay pipe, so the far side answers promptly or a few cycles late
    always_comb begin
        te_nxt = {te_r[1:0], req_te};
        trig_nxt = {trig_r[1:0], req_trig};
        mst_nxt = {mst_r[1:0], req_master};
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            te_r <= 3'h0;
            trig_r <= 3'h0;
            mst_r <= 3'h0;
        end else begin
            te_r <= te_nxt;
            trig_r <= trig_nxt;
            mst_r <= mst_nxt;
        end
    end
    // Lag zero passes the request straight through
    assign te_drv = (lag == 2'h0) ? req_te : te_r[lag - 2'h1];
    assign trig_drv = (lag == 2'h0) ? req_trig : trig_r[lag - 2'h1];
    assign mst_drv = (lag == 2'h0) ? req_master : mst_r[lag - 2'h1];
    // Wired-or: a line reads asserted while any party pulls it
    assign bp_trig_en_i = te_drv | te_oe;
    assign bp_trig_i = trig_drv | trig_oe;
    assign bp_master_en_i = mst_drv;
endmodule // ati_far_model

// ### sim/test_analyzer_trigger_interaction.sv
// Self-checking bench for the trigger interaction block.
// Assumes the far-end model and an APB slave that may insert waits.
`timescale 1ns/100ps
module test_analyzer_trigger_interaction
    import ati_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, trace_match = 1'b0, meas_done = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, triggered, meas_armed, port1_out, port2_out;
    logic bp_trig_en_i, bp_trig_en_o, bp_trig_en_oe, bp_trig_i, bp_trig_o;
    logic bp_trig_oe, bp_master_en_i, bp_delay_clk_o, bp_delay_clk_oe, err;
    logic req_te = 1'b0, req_trig = 1'b0, req_master = 1'b0;
    logic [1:0] lag = 2'h0;
    int n_mismatch = 0, checked = 0;
    // Corner cases: ctrl in [15:4], then trace, ext trig, te line, master
    logic [15:0] corner [9] = '{16'h2898, 16'h2899, 16'h0939, 16'h097b,
        16'h0439, 16'h0675, 16'h0875, 16'h1a59, 16'h0849};

    always #5 pclk = ~pclk;

    ati_trigger i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trace_match(trace_match), .meas_done(meas_done),
        .triggered(triggered), .meas_armed(meas_armed),
        .port1_out(port1_out), .port2_out(port2_out),
        .bp_trig_en_i(bp_trig_en_i), .bp_trig_en_o(bp_trig_en_o),
        .bp_trig_en_oe(bp_trig_en_oe), .bp_trig_i(bp_trig_i),
        .bp_trig_o(bp_trig_o), .bp_trig_oe(bp_trig_oe),
        .bp_master_en_i(bp_master_en_i), .bp_delay_clk_o(bp_delay_clk_o),
        .bp_delay_clk_oe(bp_delay_clk_oe));

    ati_far_model i_far (.pclk(pclk), .presetn(presetn), .lag(lag),
        .req_te(req_te), .req_trig(req_trig), .req_master(req_master),
        .te_oe(bp_trig_en_oe), .trig_oe(bp_trig_oe),
        .bp_trig_en_i(bp_trig_en_i), .bp_trig_i(bp_trig_i),
        .bp_master_en_i(bp_master_en_i));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; data and error are taken at the pready edge
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Expected {armed, triggered, trig oe, te oe, delay clock oe}
    function automatic logic [4:0] expect_f(input logic [31:0] c,
            input logic [3:0] s);
        logic [1:0] te, xt;
        logic armed, own, trig;
        te = c[ATI_TE_LSB +: 2];
        xt = c[ATI_XT_LSB +: 2];
        // Ports and delay clock count as interaction options too
        armed = !(c[ATI_WIDE_BIT] && (te != 2'h0 || xt != 2'h0 ||
            c[ATI_P1_BIT] || c[ATI_P2_BIT] || c[ATI_DC_BIT]) && !s[0]);
        own = c[ATI_INT_BIT] && s[3] && (te != ATI_TE_RECV || s[1]);
        trig = armed && (own || (xt[1] && s[2]));
        return {armed, trig, trig && (xt == ATI_XT_BOTH ||
            (xt == ATI_XT_DRIVE && own)), trig && te == ATI_TE_DRIVE,
            trig && c[ATI_DC_BIT]};
    endfunction

    task automatic run_case(input logic [31:0] c, input logic [3:0] s);
        logic [4:0] e;
        int n1, n2;
        e = expect_f(c, s);
        n1 = 0;
        n2 = 0;
        // Quiet the block first so a restart cannot retrigger at once
        apb(1'b1, ATI_CTRL_OFS, 32'h0);
        req_te <= 1'b0;
        req_trig <= 1'b0;
        req_master <= 1'b0;
        repeat (10) @(posedge pclk);
        apb(1'b1, ATI_CMD_OFS, 32'h1);
        repeat (10) @(posedge pclk);
        apb(1'b0, ATI_STAT_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, ATI_CTRL_OFS, c);
        apb(1'b0, ATI_CTRL_OFS, 32'h0);
        chk(rd, c);
        req_te <= s[1];
        req_trig <= s[2];
        req_master <= s[0];
        for (int i = 0; i < 40; i++) begin
            @(posedge pclk);
            trace_match <= (i == 16) && s[3];
            if (port1_out !== (c[ATI_P1_BIT] && c[ATI_FALL_BIT])) n1++;
        end
        chk({27'h0, meas_armed, triggered, bp_trig_oe, bp_trig_en_oe,
            bp_delay_clk_oe}, {27'h0, e});
        chk(32'(n1), (e[3] && c[ATI_P1_BIT]) ? 32'(ATI_PULSE_CYC) : 32'h0);
        meas_done <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            @(posedge pclk);
            meas_done <= 1'b0;
            if (port2_out !== (c[ATI_P2_BIT] && c[ATI_FALL_BIT])) n2++;
        end
        chk(32'(n2), (e[3] && c[ATI_P2_BIT]) ? 32'(ATI_PULSE_CYC) : 32'h0);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Main sequence: reset, register map, corners, then random settings
    initial begin
        logic [31:0] c;
        logic [3:0] s;
        void'($urandom(32'hdb42));
        repeat (16) @(posedge pclk);
        chk({23'h0, triggered, port1_out, port2_out, bp_trig_oe,
            bp_trig_en_oe, bp_delay_clk_oe, bp_trig_en_o, bp_trig_o,
            bp_delay_clk_o}, 32'h0);
        presetn <= 1'b1;
        apb(1'b0, ATI_CTRL_OFS, 32'h0);
        chk(rd, ATI_CTRL_RST);
        apb(1'b0, ATI_CMD_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h00c, 32'hffff_ffff);
        chk(32'(err), 32'h1);
        apb(1'b0, 12'h00c, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        foreach (corner[k]) run_case({20'h0, corner[k][15:4]}, corner[k][3:0]);
        for (int k = 0; k < 40; k++) begin
            c = 32'($urandom % 8) | (32'($urandom % 3) << ATI_TE_LSB) |
                (32'($urandom % 4) << ATI_XT_LSB) |
                (32'($urandom % 8) << ATI_INT_BIT);
            s = 4'($urandom % 16);
            if (c[ATI_WIDE_BIT]) s[0] = 1'b1;
            lag <= 2'($urandom % 4);
            run_case(c, s);
        end
        results();
    end

    // Watchdog, far beyond the some 4700 cycles the sequence needs
    initial begin
        #500_000;
        n_mismatch++;
        results();
    end
endmodule // test_analyzer_trigger_interaction
